/* File: core/energy_accum_and_var_calc.sv */
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Absolute mode accumulates magnitude, skips no-load
// - Pulse follows absolute mode; off after reset
// - Direction and no-load detection stay active
// - Active-low pulse rate tracks gained power
// - Line energy over programmed half cycles
// - Cycle end sets flag, gated interrupt
// - Next period starts at once, overwrites
// - Count high-byte write clears, restarts at crossing
// - Line and active energy share increment
// - Voltage times shifted current, then filtered
// - Reactive filter same as active filter
// - Selected samples shown at chosen rate
// - Reactive gain is one plus g/4096
// - Reactive gain resolution equals active gain
// - Signed offset, 256 counts per sample LSB
// - Positive-only wins over absolute mode
// - Two-bit no-load field picks threshold
module energy_accum_and_var_calc
  import metering_pkg::*;
#(
  parameter int SW = SAMPLE_W,
  parameter int unsigned PULSE_STEP = PULSE_STEP_DEF
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic sample_valid,
  input wire logic signed [SW-1:0] volt_sample,
  input wire logic signed [SW-1:0] curr_sample,
  input wire logic signed [GAIN_W-1:0] active_power_gain,
  output logic energy_pulse_out_n,
  output logic irq_pending,
  output logic [WAVE_W-1:0] active_energy,
  output logic [WAVE_W-1:0] line_active_energy,
  output logic [WAVE_W-1:0] wave_sample,
  output logic wave_valid,
  output logic no_load_flag,
  output logic power_negative
);
  localparam int PW = 2 * SW;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] wsel_reg;
  logic [7:0] no_load_threshold_cfg_reg;
  logic [7:0] accumulation_mode_cfg_reg;
  logic [7:0] irqen_reg;
  logic [7:0] irqst_reg;
  logic [HCC_W-1:0] hcc_reg;
  logic signed [GAIN_W-1:0] rgain_reg;
  logic signed [OFS_W-1:0] rofs_reg;
  logic wr;
  logic cnt_wr;
  logic cyc_end;

  assign wr = ce && sfr_req.we;
  assign cnt_wr = wr && (sfr_req.addr == ADDR_HCC_HI);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wsel_reg <= REG8_RST;
      no_load_threshold_cfg_reg <= REG8_RST;
      accumulation_mode_cfg_reg <= REG8_RST;
      irqen_reg <= REG8_RST;
      hcc_reg <= REG16_RST;
      rgain_reg <= RGAIN_RST;
      rofs_reg <= REG16_RST;
    end else if (wr) begin
      case (sfr_req.addr)
        ADDR_WAVSEL: wsel_reg <= sfr_req.wdata;
        ADDR_NO_LOAD_THRESHOLD_CFG: no_load_threshold_cfg_reg <= sfr_req.wdata;
        ADDR_ACCUMULATION_MODE_CFG: accumulation_mode_cfg_reg <= sfr_req.wdata;
        ADDR_IRQEN3: irqen_reg <= sfr_req.wdata;
        ADDR_HCC_LO: hcc_reg[7:0] <= sfr_req.wdata;
        ADDR_HCC_HI: hcc_reg[15:8] <= sfr_req.wdata;
        ADDR_RGAIN_LO: rgain_reg[7:0] <= sfr_req.wdata;
        ADDR_RGAIN_HI: rgain_reg[11:8] <= sfr_req.wdata[3:0];
        ADDR_ROFS_LO: rofs_reg[7:0] <= sfr_req.wdata;
        ADDR_ROFS_HI: rofs_reg[15:8] <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  // Write one to clear; a cycle end in the same cycle still wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqst_reg <= REG8_RST;
    end else if (ce) begin
      irqst_reg[CYCLE_END_BIT] <= cyc_end || (irqst_reg[CYCLE_END_BIT] &&
        !(sfr_req.we && sfr_req.addr == ADDR_IRQST3 &&
          sfr_req.wdata[CYCLE_END_BIT]));
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_pending <= 1'b0;
    end else if (ce) begin
      irq_pending <= irqst_reg[CYCLE_END_BIT] &&
        irqen_reg[CYCLE_END_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (ce) begin
      case (sfr_req.addr)
        ADDR_WAVSEL: sfr_rdata <= wsel_reg;
        ADDR_NO_LOAD_THRESHOLD_CFG: sfr_rdata <= no_load_threshold_cfg_reg;
        ADDR_ACCUMULATION_MODE_CFG: sfr_rdata <= accumulation_mode_cfg_reg;
        ADDR_IRQEN3: sfr_rdata <= irqen_reg;
        ADDR_IRQST3: sfr_rdata <= irqst_reg;
        ADDR_HCC_LO: sfr_rdata <= hcc_reg[7:0];
        ADDR_HCC_HI: sfr_rdata <= hcc_reg[15:8];
        ADDR_RGAIN_LO: sfr_rdata <= rgain_reg[7:0];
        ADDR_RGAIN_HI: sfr_rdata <= {4'h0, rgain_reg[11:8]};
        ADDR_ROFS_LO: sfr_rdata <= rofs_reg[7:0];
        ADDR_ROFS_HI: sfr_rdata <= rofs_reg[15:8];
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase shifter is a lagging one-pole stage, negated to lead; its gain
  // falls with frequency, so harmonics barely reach the reactive result
  logic signed [SW-1:0] ps_out;
  logic signed [SW-1:0] curr_q;
  logic signed [PW-1:0] prod_p_reg;
  logic signed [PW-1:0] prod_q_reg;
  logic signed [PW-1:0] p_f;
  logic signed [PW-1:0] q_f;
  logic s1_vld;
  logic s2_vld;
  logic s3_vld;

  lowpass_filter #(.W(SW), .SHIFT(PHASE_SHIFT)) u_phase (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .in_valid(sample_valid),
    .din(curr_sample),
    .dout(ps_out)
  );
  assign curr_q = -ps_out;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prod_p_reg <= '0;
      prod_q_reg <= '0;
    end else if (ce && sample_valid) begin
      prod_p_reg <= volt_sample * curr_sample;
      prod_q_reg <= volt_sample * curr_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_vld <= 1'b0;
      s2_vld <= 1'b0;
      s3_vld <= 1'b0;
    end else if (ce) begin
      s1_vld <= sample_valid;
      s2_vld <= s1_vld;
      s3_vld <= s2_vld;
    end
  end

  lowpass_filter #(.W(PW), .SHIFT(SECOND_LOWPASS_FILTER_SHIFT)) u_second_lowpass_p (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .in_valid(s1_vld),
    .din(prod_p_reg),
    .dout(p_f)
  );
  lowpass_filter #(.W(PW), .SHIFT(SECOND_LOWPASS_FILTER_SHIFT)) u_second_lowpass_q (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .in_valid(s1_vld),
    .din(prod_q_reg),
    .dout(q_f)
  );

  ////////////////////////////////////////////////////////////////////////
  logic signed [PW+GAIN_W-1:0] p_scl;
  logic signed [PW+GAIN_W-1:0] q_scl;
  logic signed [PW-1:0] p_g_reg;
  logic signed [PW-1:0] q_int_reg;
  assign p_scl = p_f * active_power_gain;
  assign q_scl = q_f * rgain_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      p_g_reg <= '0;
      q_int_reg <= '0;
    end else if (ce && s2_vld) begin
      p_g_reg <= p_f + PW'(p_scl >>> GAIN_SHIFT);
      q_int_reg <= q_f + PW'(q_scl >>> GAIN_SHIFT)
        + PW'(rofs_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [PW-1:0] p_abs;
  logic [PW-1:0] nl_thr;
  logic [1:0] nl_field;
  logic nl_below;
  logic signed [PW-1:0] incr;
  logic [ACC_W-1:0] incr_ext;
  logic [ACC_W-1:0] e_acc_reg;
  logic [ACC_W-1:0] line_acc_reg;

  assign nl_field = no_load_threshold_cfg_reg[NL_FIELD_LSB +: 2];

  always_comb begin
    p_abs = p_g_reg[PW-1] ? PW'(-p_g_reg) : PW'(p_g_reg);
    case (nl_field)
      2'b01: nl_thr = NL_THR_1;
      2'b10: nl_thr = NL_THR_2;
      2'b11: nl_thr = NL_THR_3;
      default: nl_thr = '0;
    endcase
    nl_below = (nl_field != 2'b00) && (p_abs < nl_thr);
    if (nl_below) begin
      incr = '0;
    end else if (accumulation_mode_cfg_reg[POS_ONLY_BIT]) begin
      incr = p_g_reg[PW-1] ? '0 : p_g_reg;
    end else if (accumulation_mode_cfg_reg[ABS_MODE_BIT]) begin
      incr = p_abs;
    end else begin
      incr = p_g_reg;
    end
  end
  assign incr_ext = {{(ACC_W-PW){incr[PW-1]}}, incr};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      e_acc_reg <= '0;
      active_energy <= '0;
    end else if (ce && s3_vld) begin
      e_acc_reg <= e_acc_reg + incr_ext;
      active_energy <= e_acc_reg[ACC_W-1 -: WAVE_W];
    end
  end

  // Detection keeps running whichever accumulation mode is chosen
  always_ff @(posedge core_clk) begin
    if (srst) begin
      no_load_flag <= 1'b0;
      power_negative <= 1'b0;
    end else if (ce && s3_vld) begin
      no_load_flag <= nl_below;
      power_negative <= p_g_reg[PW-1];
    end
  end

  pulse_gen #(
    .W(PW),
    .STEP(PULSE_STEP),
    .LOW_CYC(PULSE_LOW_CYC)
  ) u_pulse (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .in_valid(s3_vld),
    .mag(incr[PW-1] ? PW'(-incr) : PW'(incr)),
    .pulse_n(energy_pulse_out_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Crossings come from the raw voltage sign; the three-cycle lag to the
  // accumulator is a fixed skew that cancels over each period
  line_state_t lc_state;
  logic [HCC_W-1:0] hc_cnt_reg;
  logic volt_neg_reg;
  logic zc;
  logic cnt_match;

  assign zc = ce && sample_valid && (volt_sample[SW-1] != volt_neg_reg);
  assign cnt_match = (hc_cnt_reg + 16'h0001) == hcc_reg;
  assign cyc_end = zc && !cnt_wr && (lc_state == LC_RUN) && cnt_match
    && (hcc_reg != 16'h0000);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      volt_neg_reg <= 1'b0;
    end else if (ce && sample_valid) begin
      volt_neg_reg <= volt_sample[SW-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lc_state <= LC_WAIT;
      hc_cnt_reg <= '0;
    end else if (ce) begin
      if (cnt_wr) begin
        lc_state <= LC_WAIT;
        hc_cnt_reg <= '0;
      end else begin
        case (lc_state)
          LC_WAIT: begin
            if (zc) begin
              lc_state <= LC_RUN;
              hc_cnt_reg <= '0;
            end
          end
          LC_RUN: begin
            if (zc) begin
              hc_cnt_reg <= cnt_match ? '0 : hc_cnt_reg + 16'h0001;
            end
          end
          default: lc_state <= LC_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      line_acc_reg <= '0;
      line_active_energy <= '0;
    end else if (ce) begin
      if (cnt_wr) begin
        line_acc_reg <= '0;
        line_active_energy <= '0;
      end else if (cyc_end) begin
        line_active_energy <= line_acc_reg[ACC_W-1 -: WAVE_W];
        line_acc_reg <= s3_vld ? incr_ext : '0;
      end else if (lc_state == LC_WAIT && zc) begin
        line_acc_reg <= '0;
      end else if (lc_state == LC_RUN && s3_vld) begin
        line_acc_reg <= line_acc_reg + incr_ext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rates 27.9, 14, 7 and 3.5 kSPS by decimating the sample strobe
  logic [2:0] dec_reg;
  logic [2:0] dec_mask;
  assign dec_mask = 3'((4'h1 << wsel_reg[1:0]) - 4'h1);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dec_reg <= '0;
      wave_valid <= 1'b0;
      wave_sample <= '0;
    end else if (ce) begin
      wave_valid <= 1'b0;
      if (s3_vld) begin
        dec_reg <= dec_reg + 3'h1;
        if (irqen_reg[WAVEFORM_SAMPLE_ENABLE_BIT] && (dec_reg & dec_mask) == 3'h0) begin
          wave_valid <= 1'b1;
          wave_sample <= wsel_reg[WSEL_SRC_BIT] ?
            q_int_reg[WAVE_FRAC +: WAVE_W] :
            p_g_reg[WAVE_FRAC +: WAVE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_abs_acc;
    ce && s3_vld && accumulation_mode_cfg_reg[ABS_MODE_BIT] &&
      !accumulation_mode_cfg_reg[POS_ONLY_BIT] && !nl_below
      |=> e_acc_reg == $past(e_acc_reg) + ACC_W'($past(p_abs));
  endproperty
  a_abs_acc: assert property (p_abs_acc)
    else $error("absolute mode did not add magnitude");

  property p_noload_hold;
    ce && s3_vld && nl_below |=> e_acc_reg == $past(e_acc_reg);
  endproperty
  a_noload_hold: assert property (p_noload_hold)
    else $error("energy moved below no-load threshold");

  property p_posonly;
    ce && s3_vld && accumulation_mode_cfg_reg[POS_ONLY_BIT] && p_g_reg[PW-1]
      |=> e_acc_reg == $past(e_acc_reg);
  endproperty
  a_posonly: assert property (p_posonly)
    else $error("negative power accumulated in positive-only mode");

  property p_mode_rst;
    @(posedge core_clk) disable iff (1'b0)
      srst |=> accumulation_mode_cfg_reg == REG8_RST;
  endproperty
  a_mode_rst: assert property (p_mode_rst)
    else $error("accumulation mode not cleared by reset");

  property p_cyc_flag;
    cyc_end |=> irqst_reg[CYCLE_END_BIT] && hc_cnt_reg == '0
      && lc_state == LC_RUN;
  endproperty
  a_cyc_flag: assert property (p_cyc_flag)
    else $error("cycle end did not set flag and restart");

  property p_irq;
    ce && irqst_reg[CYCLE_END_BIT] && irqen_reg[CYCLE_END_BIT]
      |=> irq_pending;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled cycle-end flag raised no interrupt");

  property p_cnt_wr;
    cnt_wr |=> line_active_energy == '0 && lc_state == LC_WAIT
      && line_acc_reg == '0;
  endproperty
  a_cnt_wr: assert property (p_cnt_wr)
    else $error("count write did not restart line accumulation");

  property p_line_latch;
    cyc_end |=> line_active_energy ==
      $past(line_acc_reg[ACC_W-1 -: WAVE_W]);
  endproperty
  a_line_latch: assert property (p_line_latch)
    else $error("line energy not overwritten at cycle end");

  property p_nl_off;
    ce && s3_vld && nl_field == 2'b00 |=> !no_load_flag;
  endproperty
  a_nl_off: assert property (p_nl_off)
    else $error("no-load active while disabled");

  c_cyc_end: cover property (cyc_end);
  c_wave: cover property (wave_valid && wsel_reg[WSEL_SRC_BIT]);
  c_pulse: cover property ($fell(energy_pulse_out_n));
  c_rewrite: cover property (cnt_wr ##[1:200] zc);
endmodule
`default_nettype wire

/* File: core/lowpass_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module lowpass_filter #(
  parameter int W = 32,
  parameter int SHIFT = 6
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic signed [W-1:0] din,
  output logic signed [W-1:0] dout
);
  logic signed [W:0] diff;
  assign diff = {din[W-1], din} - {dout[W-1], dout};
  // One-pole section; the same shape serves every average in the block
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dout <= '0;
    end else if (ce && in_valid) begin
      dout <= dout + W'(diff >>> SHIFT);
    end
  end
endmodule
`default_nettype wire

/* File: core/metering_pkg.sv */
package metering_pkg;
  localparam int SAMPLE_W = 16;
  localparam int PROD_W = 32;
  localparam int ACC_W = 49;
  localparam int GAIN_W = 12;
  localparam int GAIN_SHIFT = 12;
  localparam int OFS_W = 16;
  localparam int HCC_W = 16;
  localparam int WAVE_FRAC = 8;
  localparam int WAVE_W = 24;
  localparam int SECOND_LOWPASS_FILTER_SHIFT = 6;
  localparam int PHASE_SHIFT = 8;
  localparam logic [7:0] ADDR_WAVSEL = 8'h0d;
  localparam logic [7:0] ADDR_NO_LOAD_THRESHOLD_CFG = 8'h0e;
  localparam logic [7:0] ADDR_ACCUMULATION_MODE_CFG = 8'h0f;
  localparam logic [7:0] ADDR_IRQEN3 = 8'hdb;
  localparam logic [7:0] ADDR_IRQST3 = 8'hde;
  localparam logic [7:0] ADDR_HCC_LO = 8'h10;
  localparam logic [7:0] ADDR_HCC_HI = 8'h11;
  localparam logic [7:0] ADDR_RGAIN_LO = 8'h12;
  localparam logic [7:0] ADDR_RGAIN_HI = 8'h13;
  localparam logic [7:0] ADDR_ROFS_LO = 8'h14;
  localparam logic [7:0] ADDR_ROFS_HI = 8'h15;
  localparam int POS_ONLY_BIT = 0;
  localparam int ABS_MODE_BIT = 1;
  localparam int NL_FIELD_LSB = 0;
  localparam int CYCLE_END_BIT = 2;
  localparam int WAVEFORM_SAMPLE_ENABLE_BIT = 5;
  localparam int WSEL_SRC_BIT = 2;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [11:0] RGAIN_RST = 12'h000;
  localparam logic [PROD_W-1:0] NL_THR_1 =
    PROD_W'((64'd2147483648 * 64'd150) / 64'd1000000);
  localparam logic [PROD_W-1:0] NL_THR_2 =
    PROD_W'((64'd2147483648 * 64'd75) / 64'd1000000);
  localparam logic [PROD_W-1:0] NL_THR_3 =
    PROD_W'((64'd2147483648 * 64'd37) / 64'd1000000);
  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_LOW_NS = 100000;
  localparam int PULSE_LOW_CYC =
    (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_STEP_DEF = 16777216;
  typedef struct packed {
    logic [7:0] addr;
    logic we;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef enum logic [1:0] {
    LC_WAIT = 2'b01,
    LC_RUN = 2'b10
  } line_state_t;
endpackage

/* File: core/pulse_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module pulse_gen #(
  parameter int W = 32,
  parameter int unsigned STEP = 16777216,
  parameter int LOW_CYC = 1000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] mag,
  output logic pulse_n
);
  logic [W:0] acc_reg;
  logic [W:0] sum;
  logic [15:0] low_reg;
  logic hit;
  assign sum = acc_reg + {1'b0, mag};
  assign hit = in_valid && (sum >= (W+1)'(STEP));
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_reg <= '0;
    end else if (ce && in_valid) begin
      acc_reg <= hit ? sum - (W+1)'(STEP) : sum;
    end
  end
  // A new quantum restarts the low time rather than queueing pulses
  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_reg <= '0;
      pulse_n <= 1'b1;
    end else if (ce) begin
      if (hit) begin
        low_reg <= 16'(LOW_CYC);
        pulse_n <= 1'b0;
      end else if (low_reg != 16'h0000) begin
        low_reg <= low_reg - 16'h0001;
        pulse_n <= (low_reg == 16'h0001);
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/energy_accum_and_var_calc_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module energy_accum_and_var_calc_tb_top
  import metering_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic sample_valid = 1'b0;
  logic signed [15:0] volt_sample = 16'sh0000;
  logic signed [15:0] curr_sample = 16'sh0000;
  logic signed [GAIN_W-1:0] active_power_gain = 12'sh000;
  sfr_req_t sfr_req;
  logic [7:0] sfr_rdata;
  logic energy_pulse_out_n, irq_pending, wave_valid;
  logic no_load_flag, power_negative;
  logic [WAVE_W-1:0] active_energy, line_active_energy, wave_sample;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int wv_cnt = 0;
  int pl_cnt = 0;
  logic [7:0] rdv;

  always #50 core_clk = ~core_clk;

  energy_accum_and_var_calc #(.PULSE_STEP(4096)) uut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sample_valid(sample_valid),
    .volt_sample(volt_sample), .curr_sample(curr_sample),
    .active_power_gain(active_power_gain),
    .energy_pulse_out_n(energy_pulse_out_n), .irq_pending(irq_pending),
    .active_energy(active_energy), .line_active_energy(line_active_energy),
    .wave_sample(wave_sample), .wave_valid(wave_valid),
    .no_load_flag(no_load_flag), .power_negative(power_negative)
  );

  host_core_model host (
    .core_clk(core_clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req)
  );

  // Event counters; scenarios compare differences, never clear them
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wave_valid === 1'b1) wv_cnt <= wv_cnt + 1;
    if (energy_pulse_out_n === 1'b0) pl_cnt <= pl_cnt + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask

  // Samples spaced eight cycles apart, above the pipeline depth
  task automatic send(input int v, input int c, input int n);
    repeat (n) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      volt_sample <= 16'(v);
      curr_sample <= 16'(c);
      @(posedge core_clk);
      sample_valid <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic sc_reset_values();
    logic [7:0] addrs [11] = '{8'h0d, 8'h0e, 8'h0f, 8'hdb, 8'hde, 8'h10,
      8'h11, 8'h12, 8'h14, 8'h15, 8'h20};
    do_reset();
    check(energy_pulse_out_n, 1);
    foreach (addrs[i]) begin
      host.rd(addrs[i], rdv);
      check(rdv, 0);
    end
  endtask

  // Negative power in absolute mode still adds and pulses
  task automatic sc_absolute();
    int p0;
    do_reset();
    host.wr(8'h0f, 8'h02);
    host.rd(8'h0f, rdv);
    check(rdv, 8'h02);
    p0 = pl_cnt;
    send(16000, -16000, 300);
    check(active_energy[23], 0);
    check(active_energy == 24'h0, 0);
    check(power_negative, 1);
    check(pl_cnt > p0, 1);
  endtask

  // Clock enable low freezes the pipeline; those samples are lost
  task automatic sc_signed();
    logic [23:0] e0;
    do_reset();
    send(16000, -16000, 300);
    check(active_energy[23], 1);
    e0 = active_energy;
    ce <= 1'b0;
    send(16000, -16000, 8);
    ce <= 1'b1;
    @(posedge core_clk);
    check(active_energy, e0);
  endtask

  // Both mode bits: positive-only wins, so negative power is dropped
  task automatic sc_both_bits();
    int p0;
    do_reset();
    host.wr(8'h0f, 8'h03);
    p0 = pl_cnt;
    send(16000, -16000, 300);
    check(active_energy, 0);
    check(pl_cnt - p0, 0);
  endtask

  // Detection stays on in absolute mode; about 100000 of power lies
  // above the smallest threshold and below the largest
  task automatic sc_no_load();
    do_reset();
    host.wr(8'h0f, 8'h02);
    for (int m = 1; m < 4; m++) begin
      host.wr(8'h0e, 8'(m));
      send(16000, 0, 4);
      check(no_load_flag, 1);
    end
    host.wr(8'h0e, 8'h00);
    send(16000, 0, 4);
    check(no_load_flag, 0);
    host.wr(8'h0e, 8'h03);
    send(400, 400, 64);
    check(no_load_flag, 0);
    host.wr(8'h0e, 8'h01);
    send(400, 400, 4);
    check(no_load_flag, 1);
  endtask

  // Two half cycles: start at first crossing, end at the third
  task automatic sc_line_cycle();
    logic [23:0] l0;
    do_reset();
    send(16000, 16000, 4);
    host.wr(8'h10, 8'h02);
    host.wr(8'h11, 8'h00);
    host.wr(8'hdb, 8'h04);
    send(-16000, -16000, 4);
    send(16000, 16000, 4);
    host.rd(8'hde, rdv);
    check(rdv & 8'h04, 0);
    check(irq_pending, 0);
    send(-16000, -16000, 4);
    host.rd(8'hde, rdv);
    check(rdv & 8'h04, 8'h04);
    check(irq_pending, 1);
    check(line_active_energy == 24'h0, 0);
    host.wr(8'hde, 8'h04);
    host.rd(8'hde, rdv);
    check(rdv & 8'h04, 0);
    check(irq_pending, 0);
    // Unread result is replaced at the next end; power is still rising
    l0 = line_active_energy;
    send(16000, 16000, 4);
    send(-16000, -16000, 4);
    check(line_active_energy > l0, 1);
    host.wr(8'h11, 8'h00);
    host.rd(8'h11, rdv);
    check(line_active_energy, 0);
  endtask

  // Zero inputs leave only the offset: 0x100 is one sample LSB
  task automatic sc_reactive_wave();
    int w0;
    do_reset();
    host.wr(8'h13, 8'hf8);
    host.rd(8'h13, rdv);
    check(rdv, 8'h08);
    host.wr(8'h14, 8'h00);
    host.wr(8'h15, 8'h01);
    host.wr(8'hdb, 8'h20);
    for (int r = 0; r < 4; r++) begin
      host.wr(8'h0d, 8'h04 | 8'(r));
      w0 = wv_cnt;
      send(0, 0, 32);
      check(wv_cnt - w0, 32 >> r);
      check(wave_sample, 24'h000001);
    end
    host.wr(8'h15, 8'hff);
    send(0, 0, 16);
    check(wave_sample, 24'hffffff);
  endtask

  initial begin
    sc_reset_values();
    sc_absolute();
    sc_signed();
    sc_both_bits();
    sc_no_load();
    sc_line_cycle();
    sc_reactive_wave();
    test_done();
  end
endmodule
`default_nettype wire

/* File: tb/host_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stands in for the processor core: byte-wide register writes and reads
module host_core_model
  import metering_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] sfr_rdata,
  output var sfr_req_t sfr_req
);
  initial begin
    sfr_req = '0;
  end

  // Write strobe stands one cycle, then drops before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_req <= '{addr: a, we: 1'b1, wdata: d};
    @(posedge core_clk);
    sfr_req.we <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_req <= '{addr: a, we: 1'b0, wdata: 8'h00};
    @(posedge core_clk);
    @(negedge core_clk);
    d = sfr_rdata;
  endtask
endmodule
`default_nettype wire
